// File: shared/ipl_pkg.sv
// Constants shared by the interrupt priority level register block.
`default_nettype none
package ipl_pkg;

   // Register indexes; the byte address is four times the index.
   localparam int unsigned IDX_W        = 6;
   localparam int unsigned ADDR_LSB     = 2;
   localparam logic [5:0]  IDX_SER_GPIO = 6'h02;
   localparam logic [5:0]  IDX_TW_SER   = 6'h03;
   localparam logic [5:0]  IDX_TMR_TW   = 6'h04;

   // Register slots, their count and the code for no slot.
   localparam int unsigned NUM_REGS  = 3;
   localparam logic [1:0]  SLOT_NONE = 2'h3;
   localparam int unsigned REG_W     = 16;

   // Writable bit masks; reserved bits are not stored and read zero.
   localparam logic [15:0] REG_MASK [NUM_REGS] =
      '{16'hc3ff, 16'hc03f, 16'hffff};
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Field encodings of a priority field.
   localparam logic [1:0] ENC_OFF = 2'h0;
   localparam logic [1:0] ENC_L0  = 2'h1;
   localparam logic [1:0] ENC_L1  = 2'h2;
   localparam logic [1:0] ENC_L2  = 2'h3;
   localparam logic [1:0] LVL_0   = 2'h0;
   localparam logic [1:0] LVL_1   = 2'h1;
   localparam logic [1:0] LVL_2   = 2'h2;

   // Source table: register slot and low bit of each field.
   localparam int unsigned NUM_SRC = 18;
   localparam int unsigned FIELD_SLOT [NUM_SRC] =
      '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2};
   localparam int unsigned FIELD_LSB [NUM_SRC] =
      '{14, 8, 6, 4, 2, 0, 14, 4, 2, 0, 14, 12, 10, 8, 6, 4, 2, 0};

   // Bus constants.
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // Data phase states of the bus slave.
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b001,
      PH_WRITE = 3'b010,
      PH_READ  = 3'b100
   } ipl_phase_t;

endpackage : ipl_pkg
`default_nettype wire

// File: core/ipl_ahb_if.sv
// AHB-Lite slave front end for the priority level registers.
`timescale 1ns/1ps
`default_nettype none
module ipl_ahb_if (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic        wr_en,
   output var  logic [ipl_pkg::IDX_W-1:0] wr_idx,
   output var  logic [15:0] wr_data,
   output var  logic [ipl_pkg::IDX_W-1:0] rd_idx,
   input  wire logic [31:0] rd_data
);
   import ipl_pkg::*;

   ipl_phase_t         phase_q;    // Kind of the current data phase.
   logic [IDX_W-1:0]   wr_idx_q;   // Index latched for a write.
   logic               word_q;     // Write was a whole word.
   logic [31:0]        hrdata_q;   // Read data held for the data phase.
   logic               take;       // Address phase accepted.

   // A transfer is taken on NONSEQ or SEQ while the bus is ready.
   assign take   = hsel && htrans[1] && hready;
   assign rd_idx = haddr[ADDR_LSB +: IDX_W];

   // Track what the next data phase carries.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q  <= PH_IDLE;
         wr_idx_q <= '0;
         word_q   <= 1'b0;
      end else if (take) begin
         phase_q  <= hwrite ? PH_WRITE : PH_READ;
         wr_idx_q <= haddr[ADDR_LSB +: IDX_W];
         word_q   <= (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0);
      end else if (hready) begin
         phase_q  <= PH_IDLE;
      end
   end

   // Read data are captured at the address phase from forwarded values.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_q <= RDATA_ZERO;
      end else if (take && !hwrite) begin
         hrdata_q <= rd_data;
      end
   end

   // Only whole word writes reach the registers.
   assign wr_en     = (phase_q == PH_WRITE) && word_q;
   assign wr_idx    = wr_idx_q;
   assign wr_data   = hwdata[15:0];
   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

endmodule : ipl_ahb_if
`default_nettype wire

// File: core/ipl_level_decode.sv
// Decoder of one priority field into a registered enable and level.
`timescale 1ns/1ps
`default_nettype none
module ipl_level_decode (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] field_d,
   output var  logic       enable_q,
   output var  logic [1:0] level_q
);
   import ipl_pkg::*;

   // Decode the next field value so outputs track the register edge.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_q <= 1'b0;
         level_q  <= LVL_0;
      end else begin
         unique case (field_d)
            ENC_OFF: begin
               enable_q <= 1'b0;
               level_q  <= LVL_0;
            end
            ENC_L0: begin
               enable_q <= 1'b1;
               level_q  <= LVL_0;
            end
            ENC_L1: begin
               enable_q <= 1'b1;
               level_q  <= LVL_1;
            end
            ENC_L2: begin
               enable_q <= 1'b1;
               level_q  <= LVL_2;
            end
         endcase
      end
   end

endmodule : ipl_level_decode
`default_nettype wire

// File: core/ipl_regs.sv
// Priority level registers for the serial, port, timer and two-wire sources.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Field 00 off, 01/10/11 give levels 0-2
// - All fields reset to zero, sources disabled
// - No field can select level three
// - Index 2 bits 15-14: async transmit empty
// - Index 2 bits 9-8: sync transmit empty
// - Index 2 bits 7-6: sync receive full
// - Index 2 ports A, B, C at 5-0
// - Index 3 bits 15-14: two-wire error
// - Index 3 async rx full, error, tx idle
// - Index 4 timer channels 3-0 at 15-8
// - Index 4 two-wire status, transmit, receive
// - Index 4 bits 1-0: two-wire general call
module ipl_regs (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output var  logic [31:0] HRDATA,
   output var  logic        HREADYOUT,
   output var  logic        HRESP,
   output var  logic        ASYNC_TX_EMPTY_EN,
   output var  logic [1:0]  ASYNC_TX_EMPTY_LEVEL,
   output var  logic        SYNC_TX_EMPTY_EN,
   output var  logic [1:0]  SYNC_TX_EMPTY_LEVEL,
   output var  logic        SYNC_RX_FULL_EN,
   output var  logic [1:0]  SYNC_RX_FULL_LEVEL,
   output var  logic        PORT_A_IO_EN,
   output var  logic [1:0]  PORT_A_IO_LEVEL,
   output var  logic        PORT_B_IO_EN,
   output var  logic [1:0]  PORT_B_IO_LEVEL,
   output var  logic        PORT_C_IO_EN,
   output var  logic [1:0]  PORT_C_IO_LEVEL,
   output var  logic        TWOWIRE_ERROR_EN,
   output var  logic [1:0]  TWOWIRE_ERROR_LEVEL,
   output var  logic        ASYNC_RX_FULL_EN,
   output var  logic [1:0]  ASYNC_RX_FULL_LEVEL,
   output var  logic        ASYNC_RX_ERROR_EN,
   output var  logic [1:0]  ASYNC_RX_ERROR_LEVEL,
   output var  logic        ASYNC_TX_IDLE_EN,
   output var  logic [1:0]  ASYNC_TX_IDLE_LEVEL,
   output var  logic        TIMER_CH3_EN,
   output var  logic [1:0]  TIMER_CH3_LEVEL,
   output var  logic        TIMER_CH2_EN,
   output var  logic [1:0]  TIMER_CH2_LEVEL,
   output var  logic        TIMER_CH1_EN,
   output var  logic [1:0]  TIMER_CH1_LEVEL,
   output var  logic        TIMER_CH0_EN,
   output var  logic [1:0]  TIMER_CH0_LEVEL,
   output var  logic        TWOWIRE_STATUS_EN,
   output var  logic [1:0]  TWOWIRE_STATUS_LEVEL,
   output var  logic        TWOWIRE_TRANSMIT_EN,
   output var  logic [1:0]  TWOWIRE_TRANSMIT_LEVEL,
   output var  logic        TWOWIRE_RECEIVE_EN,
   output var  logic [1:0]  TWOWIRE_RECEIVE_LEVEL,
   output var  logic        TWOWIRE_GENERAL_CALL_EN,
   output var  logic [1:0]  TWOWIRE_GENERAL_CALL_LEVEL
);
   import ipl_pkg::*;

   // Maps a word index onto a register slot, or to no slot.
   function automatic logic [1:0] slot_of(input logic [IDX_W-1:0] idx);
      logic [1:0] s;
      s = SLOT_NONE;
      if (idx == IDX_SER_GPIO) begin
         s = 2'h0;
      end else if (idx == IDX_TW_SER) begin
         s = 2'h1;
      end else if (idx == IDX_TMR_TW) begin
         s = 2'h2;
      end
      return s;
   endfunction : slot_of

   // Bus side signals between the slave and the register array.
   logic             wr_en;      // Whole word write in its data phase.
   logic [IDX_W-1:0] wr_idx;     // Word index of that write.
   logic [15:0]      wr_data;    // Low half of the write data.
   logic [IDX_W-1:0] rd_idx;     // Word index of a read address phase.
   logic [31:0]      rd_data;    // Forwarded read value.
   logic [1:0]       wr_slot;    // Slot hit by the write.
   logic [1:0]       rd_slot;    // Slot hit by the read.

   // Register state and its next value, one word per slot.
   logic [REG_W-1:0] regs_q [NUM_REGS];
   logic [REG_W-1:0] regs_d [NUM_REGS];

   // Per-source decoded enable and level, indexed as the source table.
   logic [NUM_SRC-1:0] src_en;
   logic [1:0]         src_lvl [NUM_SRC];

   // The AHB-Lite slave answers every transfer with no wait state.
   ipl_ahb_if u_bus (
      .clk       (CLK),
      .rst_n     (RST_N),
      .hsel      (HSEL),
      .haddr     (HADDR),
      .htrans    (HTRANS),
      .hwrite    (HWRITE),
      .hsize     (HSIZE),
      .hready    (HREADY),
      .hwdata    (HWDATA),
      .hrdata    (HRDATA),
      .hreadyout (HREADYOUT),
      .hresp     (HRESP),
      .wr_en     (wr_en),
      .wr_idx    (wr_idx),
      .wr_data   (wr_data),
      .rd_idx    (rd_idx),
      .rd_data   (rd_data)
   );

   // Decode both bus indexes with the same slot map.
   assign wr_slot = slot_of(wr_idx);
   assign rd_slot = slot_of(rd_idx);

   // Next value of each register; unmapped writes change nothing.
   always_comb begin
      for (int s = 0; s < NUM_REGS; s++) begin
         regs_d[s] = regs_q[s];
         if (wr_en && (wr_slot == s[1:0])) begin
            // Reserved bits are never stored, so they read zero.
            regs_d[s] = wr_data & REG_MASK[s];
         end
      end
   end

   // Register words take the written value at the end of the data phase.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int s = 0; s < NUM_REGS; s++) begin
            regs_q[s] <= REG_RESET;
         end
      end else begin
         for (int s = 0; s < NUM_REGS; s++) begin
            regs_q[s] <= regs_d[s];
         end
      end
   end

   // Reads see a write still in its data phase; unmapped reads give zero.
   always_comb begin
      rd_data = RDATA_ZERO;
      if (rd_slot != SLOT_NONE) begin
         rd_data = {16'h0000, regs_d[rd_slot]};
      end
   end

   // One decoder per source, fed from its field of the next value.
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      ipl_level_decode u_dec (
         .clk      (CLK),
         .rst_n    (RST_N),
         .field_d  (regs_d[FIELD_SLOT[i]][FIELD_LSB[i] +: 2]),
         .enable_q (src_en[i]),
         .level_q  (src_lvl[i])
      );
   end

   // Serial and port sources in the first register.
   assign ASYNC_TX_EMPTY_EN          = src_en[0];
   assign ASYNC_TX_EMPTY_LEVEL       = src_lvl[0];
   assign SYNC_TX_EMPTY_EN           = src_en[1];
   assign SYNC_TX_EMPTY_LEVEL        = src_lvl[1];
   assign SYNC_RX_FULL_EN            = src_en[2];
   assign SYNC_RX_FULL_LEVEL         = src_lvl[2];
   assign PORT_A_IO_EN               = src_en[3];
   assign PORT_A_IO_LEVEL            = src_lvl[3];
   assign PORT_B_IO_EN               = src_en[4];
   assign PORT_B_IO_LEVEL            = src_lvl[4];
   assign PORT_C_IO_EN               = src_en[5];
   assign PORT_C_IO_LEVEL            = src_lvl[5];

   // Two-wire error and asynchronous serial sources in the second.
   assign TWOWIRE_ERROR_EN           = src_en[6];
   assign TWOWIRE_ERROR_LEVEL        = src_lvl[6];
   assign ASYNC_RX_FULL_EN           = src_en[7];
   assign ASYNC_RX_FULL_LEVEL        = src_lvl[7];
   assign ASYNC_RX_ERROR_EN          = src_en[8];
   assign ASYNC_RX_ERROR_LEVEL       = src_lvl[8];
   assign ASYNC_TX_IDLE_EN           = src_en[9];
   assign ASYNC_TX_IDLE_LEVEL        = src_lvl[9];

   // Timer channels and two-wire events in the third.
   assign TIMER_CH3_EN               = src_en[10];
   assign TIMER_CH3_LEVEL            = src_lvl[10];
   assign TIMER_CH2_EN               = src_en[11];
   assign TIMER_CH2_LEVEL            = src_lvl[11];
   assign TIMER_CH1_EN               = src_en[12];
   assign TIMER_CH1_LEVEL            = src_lvl[12];
   assign TIMER_CH0_EN               = src_en[13];
   assign TIMER_CH0_LEVEL            = src_lvl[13];
   assign TWOWIRE_STATUS_EN          = src_en[14];
   assign TWOWIRE_STATUS_LEVEL       = src_lvl[14];
   assign TWOWIRE_TRANSMIT_EN        = src_en[15];
   assign TWOWIRE_TRANSMIT_LEVEL     = src_lvl[15];
   assign TWOWIRE_RECEIVE_EN         = src_en[16];
   assign TWOWIRE_RECEIVE_LEVEL      = src_lvl[16];
   assign TWOWIRE_GENERAL_CALL_EN    = src_en[17];
   assign TWOWIRE_GENERAL_CALL_LEVEL = src_lvl[17];

endmodule : ipl_regs
`default_nettype wire

// File: tb/ipl_regs_monitor.sv
// Checker of the bus and of two source outputs of the priority registers.
`timescale 1ns/1ps
`default_nettype none
module ipl_regs_monitor (
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [2:0]  HSIZE,
   input wire logic        HREADY,
   input wire logic [31:0] HWDATA,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        TIMER_CH3_EN,
   input wire logic [1:0]  TIMER_CH3_LEVEL,
   input wire logic        TWOWIRE_GENERAL_CALL_EN,
   input wire logic [1:0]  TWOWIRE_GENERAL_CALL_LEVEL
);
   logic       take;   // An address phase is taken.
   logic [1:0] tm_f;   // Timer channel 3 field on the write data.
   logic [1:0] tm_l;   // Level that field should give.
   logic [1:0] gc_f;   // General call field on the read data.
   assign take = HSEL && HTRANS[1] && HREADY;
   assign tm_f = HWDATA[15:14];
   assign tm_l = (tm_f == 2'h0) ? 2'h0 : tm_f - 2'h1;
   assign gc_f = HRDATA[1:0];
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_bus_ready_okay: assert property (HREADYOUT && !HRESP)
      else $error("wait state or error response");
   a_reset_all_off: assert property ($rose(RST_N) |->
      !TIMER_CH3_EN && !TWOWIRE_GENERAL_CALL_EN && HRDATA == 32'h0)
      else $error("not cleared after reset");
   a_rsvd_two_zero: assert property (take && !HWRITE &&
      HADDR[7:2] == 6'h02 |=> HRDATA[13:10] == 4'h0)
      else $error("reserved bits of index 2 not zero");
   a_rsvd_three_zero: assert property (take && !HWRITE &&
      HADDR[7:2] == 6'h03 |=> HRDATA[13:6] == 8'h00)
      else $error("reserved bits of index 3 not zero");
   a_off_level_zero: assert property (!TIMER_CH3_EN |->
      TIMER_CH3_LEVEL == 2'h0) else $error("disabled source has level");
   a_no_level_three: assert property (TIMER_CH3_LEVEL != 2'h3 &&
      TWOWIRE_GENERAL_CALL_LEVEL != 2'h3) else $error("level three seen");
   a_timer_write_lands: assert property (take && HWRITE &&
      HSIZE == 3'h2 && HADDR[7:0] == 8'h10 |=> ##1
      {TIMER_CH3_EN, TIMER_CH3_LEVEL} ==
      {$past(tm_f) != 2'h0, $past(tm_l)}) else $error("timer field wrong");
   a_gcall_decode: assert property (take && !HWRITE &&
      HADDR[7:2] == 6'h04 |=> TWOWIRE_GENERAL_CALL_EN == (gc_f != 2'h0)
      && TWOWIRE_GENERAL_CALL_LEVEL == ((gc_f == 2'h0) ? 2'h0 : gc_f - 2'h1))
      else $error("general call decode wrong");
   c_write_four: cover property (take && HWRITE && HADDR[7:2] == 6'h04);
   c_read_two: cover property (take && !HWRITE && HADDR[7:2] == 6'h02);
   c_gcall_top: cover property (TWOWIRE_GENERAL_CALL_LEVEL == 2'h2);
endmodule : ipl_regs_monitor
bind ipl_regs ipl_regs_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_CH3_EN(TIMER_CH3_EN),
   .TIMER_CH3_LEVEL(TIMER_CH3_LEVEL),
   .TWOWIRE_GENERAL_CALL_EN(TWOWIRE_GENERAL_CALL_EN),
   .TWOWIRE_GENERAL_CALL_LEVEL(TWOWIRE_GENERAL_CALL_LEVEL));
`default_nettype wire

// File: tb/test_ipl_regs.sv
// Self-checking bench of the priority level registers.
`timescale 1ns/1ps
`default_nettype none
module test_ipl_regs;
   import ipl_pkg::*;
   logic        clk, rst_n, hsel, hwrite, hready, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [53:0] o;              // Enable and level, source 0 on top.
   logic [15:0] mdl [3];        // Model of the three registers.
   logic [15:0] msk [3] = '{16'hc3ff, 16'hc03f, 16'hffff};
   int          lsb [18] = '{14, 8, 6, 4, 2, 0, 14, 4, 2, 0,
                             14, 12, 10, 8, 6, 4, 2, 0};
   logic [31:0] seed;
   int          miscompares, checks_done;
   ipl_regs u_dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hready),
      .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .ASYNC_TX_EMPTY_EN(o[53]), .ASYNC_TX_EMPTY_LEVEL(o[52:51]),
      .SYNC_TX_EMPTY_EN(o[50]), .SYNC_TX_EMPTY_LEVEL(o[49:48]),
      .SYNC_RX_FULL_EN(o[47]), .SYNC_RX_FULL_LEVEL(o[46:45]),
      .PORT_A_IO_EN(o[44]), .PORT_A_IO_LEVEL(o[43:42]),
      .PORT_B_IO_EN(o[41]), .PORT_B_IO_LEVEL(o[40:39]),
      .PORT_C_IO_EN(o[38]), .PORT_C_IO_LEVEL(o[37:36]),
      .TWOWIRE_ERROR_EN(o[35]), .TWOWIRE_ERROR_LEVEL(o[34:33]),
      .ASYNC_RX_FULL_EN(o[32]), .ASYNC_RX_FULL_LEVEL(o[31:30]),
      .ASYNC_RX_ERROR_EN(o[29]), .ASYNC_RX_ERROR_LEVEL(o[28:27]),
      .ASYNC_TX_IDLE_EN(o[26]), .ASYNC_TX_IDLE_LEVEL(o[25:24]),
      .TIMER_CH3_EN(o[23]), .TIMER_CH3_LEVEL(o[22:21]),
      .TIMER_CH2_EN(o[20]), .TIMER_CH2_LEVEL(o[19:18]),
      .TIMER_CH1_EN(o[17]), .TIMER_CH1_LEVEL(o[16:15]),
      .TIMER_CH0_EN(o[14]), .TIMER_CH0_LEVEL(o[13:12]),
      .TWOWIRE_STATUS_EN(o[11]), .TWOWIRE_STATUS_LEVEL(o[10:9]),
      .TWOWIRE_TRANSMIT_EN(o[8]), .TWOWIRE_TRANSMIT_LEVEL(o[7:6]),
      .TWOWIRE_RECEIVE_EN(o[5]), .TWOWIRE_RECEIVE_LEVEL(o[4:3]),
      .TWOWIRE_GENERAL_CALL_EN(o[2]), .TWOWIRE_GENERAL_CALL_LEVEL(o[1:0]));
   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Next value of the stimulus sequence.
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // Compares one result with its expectation and counts it.
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : compare
   // One single transfer at the set size; read data is taken at the data phase end.
   task automatic xfer(input logic w, input logic [5:0] idx,
                       input logic [31:0] wd, output logic [31:0] rv);
      hwrite <= w;
      htrans <= 2'h2;
      haddr <= {24'h0, idx, 2'b00};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rv = hrdata;
   endtask : xfer
   // Writes a word, reserved bits kept zero, and mirrors it in the model.
   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      logic ok;
      ok = idx >= 6'h02 && idx <= 6'h04;
      if (ok) d = d & msk[idx - 6'h02];
      xfer(1'b1, idx, {16'h0, d}, rd);
      if (ok) mdl[idx - 6'h02] = d;
   endtask : wr
   // Reads a word and compares it; unmapped places read zero.
   task automatic rdchk(input logic [5:0] idx);
      xfer(1'b0, idx, 32'h0, rd);
      if (idx >= 6'h02 && idx <= 6'h04)
         compare(rd, {16'h0, mdl[idx - 2]});
      else
         compare(rd, 32'h0);
   endtask : rdchk
   // Compares every enable and level with the decoded model fields.
   task automatic check_src;
      logic [1:0] f;
      #1;
      for (int k = 0; k < 18; k++) begin
         f = mdl[k < 6 ? 0 : (k < 10 ? 1 : 2)][lsb[k] +: 2];
         compare({29'h0, o[53 - 3 * k -: 3]},
                 {29'h0, f != 2'h0, (f == 2'h0) ? 2'h0 : f - 2'h1});
      end
      @(posedge clk);
   endtask : check_src
   // Prints the verdict and ends the run.
   task automatic end_sim;
      if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // Main sequence: reset values, all encodings, random words, reset.
   initial begin
      logic [5:0] idx;
      rst_n = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      haddr = 32'h0;
      hwdata = 32'h0;
      seed = 32'h557d4b88;
      mdl = '{default: 16'h0000};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      hsel <= 1'b1;
      check_src();
      for (int i = 1; i <= 5; i++) rdchk(6'(i));
      for (int e = 0; e < 4; e++) begin
         for (int i = 2; i <= 4; i++) begin
            wr(6'(i), {8{2'(e)}});
            check_src();
            rdchk(6'(i));
         end
      end
      for (int n = 0; n < 40; n++) begin
         seed = lfsr(seed);
         idx = 6'(1 + seed[18:16] % 5);
         wr(idx, seed[15:0]);
         check_src();
         rdchk(6'(2 + seed[22:20] % 3));
      end
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      mdl = '{default: 16'h0000};
      check_src();
      rdchk(6'h04);
      // A byte sized write must be ignored, so the word stays at zero.
      hsize <= 3'h0;
      xfer(1'b1, 6'h04, 32'h0000_ffff, rd);
      hsize <= HSIZE_WORD;
      rdchk(6'h04);
      check_src();
      end_sim();
   end
   // Cuts a hang short.
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_sim();
   end
endmodule : test_ipl_regs
`default_nettype wire
